// ===== fault_timer.sv
// Purpose: loadable down counter that flags when its load has run out
// Assumes: load and run are synchronous to the clock
// Notes: done rises n-1 edges after a load of n and holds while run stays high
`timescale 1ns/1ps
module fault_timer
  import line_drv_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] value,
  input wire logic run,
  output logic done
);
  logic [CNT_W-1:0] cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      done <= 1'b0;
    end else if (load) begin
      cnt_ff <= value - CNT_W'(1);
      done <= 1'b0;
    end else if (!run) begin
      cnt_ff <= '0;
      done <= 1'b0;
    end else begin
      // held, so a lasting fault or a late overtemp clear is not missed
      done <= (cnt_ff <= CNT_W'(1));
      if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - CNT_W'(1);
      end
    end
  end
endmodule

// ===== line_driver_limit_retry_ctrl.sv
// Purpose: register pair and fault retry control for the line driver
// Assumes: register port strobes are one-cycle and synchronous
// Notes: analog limit levels are passed out as codes
`timescale 1ns/1ps
module line_driver_limit_retry_ctrl
  import line_drv_pkg::*;
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // register port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // driver analog status
  input wire logic i_in_limit,
  input wire logic i_overtemp,
  // driver controls
  output logic o_drv_enable,
  output logic [1:0] o_current_limit_level,
  output logic o_limit_active,
  output logic o_fault,
  // general controls
  output logic o_reg3v3_off,
  output logic o_wake_detect_off,
  output logic o_receive_output_off
);
  limit_cfg_t cfg_ff;
  logic [7:0] ctrl_ff;
  drv_state_t state_ff;
  drv_state_t nxt_state;
  logic blank_done;
  logic retry_done;
  logic oc_fault;
  logic enter_off;
  logic limit_phase_ff;

  function automatic logic [CNT_W-1:0] blank_cycles(input logic [1:0] sel);
    case (sel)
      2'b00: blank_cycles = BLANK_CYC0;
      2'b01: blank_cycles = BLANK_CYC1;
      2'b10: blank_cycles = BLANK_CYC2;
      default: blank_cycles = BLANK_CYC3;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] retry_cycles(input logic [1:0] sel);
    case (sel)
      2'b00: retry_cycles = RETRY_CYC0;
      2'b01: retry_cycles = RETRY_CYC1;
      2'b10: retry_cycles = RETRY_CYC2;
      default: retry_cycles = RETRY_CYC3;
    endcase
  endfunction

  // register writes
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_ff <= RST_LIMIT_CFG;
      ctrl_ff <= RST_GEN_CTRL;
    end else if (i_wr) begin
      if (i_addr == ADDR_LIMIT_CFG) begin
        cfg_ff <= i_wdata;
      end
      if (i_addr == ADDR_GEN_CTRL) begin
        ctrl_ff <= i_wdata & GEN_CTRL_MASK;
      end
    end
  end

  // register reads, one cycle latency
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        case (i_addr)
          ADDR_LIMIT_CFG: o_rdata <= cfg_ff;
          ADDR_GEN_CTRL: o_rdata <= ctrl_ff;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // blanking: limit must persist the whole blanking time
  fault_timer u_blank (
    .clk(I_MCLK),
    .rst(I_RST),
    .load(i_in_limit && !limit_phase_ff),
    .value(blank_cycles(cfg_ff.limit_blank_time)),
    .run(i_in_limit && state_ff == ST_ON),
    .done(blank_done)
  );

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      limit_phase_ff <= 1'b0;
    end else begin
      limit_phase_ff <= i_in_limit && state_ff == ST_ON;
    end
  end

  // overcurrent counts only with limit active and still limiting
  assign oc_fault = blank_done && i_in_limit && !cfg_ff.limit_disable;
  assign enter_off = i_overtemp || (cfg_ff.auto_retry_enable && oc_fault);

  // retry off-time
  fault_timer u_retry (
    .clk(I_MCLK),
    .rst(I_RST),
    .load(state_ff == ST_ON && enter_off),
    .value(retry_cycles(cfg_ff.retry_off_time)),
    .run(state_ff == ST_OFF),
    .done(retry_done)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ON: begin
        if (enter_off) begin
          nxt_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (cfg_ff.auto_retry_enable) begin
          if (retry_done && !i_overtemp) begin
            nxt_state = ST_ON;
          end
        end else if (!i_overtemp) begin
          nxt_state = ST_ON;
        end
      end
      default: nxt_state = ST_ON;
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_ff <= ST_ON;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      o_drv_enable <= 1'b0;
      o_current_limit_level <= 2'b00;
      o_limit_active <= 1'b0;
      o_fault <= 1'b0;
      o_reg3v3_off <= 1'b0;
      o_wake_detect_off <= 1'b0;
      o_receive_output_off <= 1'b0;
    end else begin
      o_drv_enable <= (nxt_state == ST_ON);
      o_current_limit_level <= cfg_ff.current_limit_level;
      o_limit_active <= !cfg_ff.limit_disable;
      o_fault <= oc_fault || i_overtemp;
      o_reg3v3_off <= ctrl_ff[POS_REG3V3_OFF];
      o_wake_detect_off <= ctrl_ff[POS_WAKE_OFF];
      o_receive_output_off <= ctrl_ff[POS_RX_OFF];
    end
  end
endmodule

// ===== line_driver_limit_retry_ctrl_tb.sv
// Purpose: bench for limit and retry control
// Assumes: 10 MHz clock
// Notes: long retry time not run out
`timescale 1ns/1ps
module line_driver_limit_retry_ctrl_tb;
  import line_drv_pkg::*;
  logic I_MCLK = 0, I_RST = 1, i_wr = 0, i_rd = 0, short_cmd = 0, hot_cmd = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, w, o_rdata;
  logic i_in_limit, i_overtemp, o_rvalid, o_drv_enable, o_limit_active, o_fault;
  logic o_reg3v3_off, o_wake_detect_off, o_receive_output_off;
  logic [1:0] o_current_limit_level;
  int err_total = 0, checks = 0;
  always #50 I_MCLK = ~I_MCLK;
  line_driver_limit_retry_ctrl dut (.*);
  line_load load (.drv_on(o_drv_enable), .short_cmd(short_cmd), .hot_cmd(hot_cmd),
    .in_limit(i_in_limit), .overtemp(i_overtemp));
  function logic [7:0] ctl_exp(input logic [7:0] d);
    return d & GEN_CTRL_MASK;
  endfunction
  task check(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge I_MCLK);
    @(negedge I_MCLK);
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge I_MCLK);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge I_MCLK);
    i_wr <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge I_MCLK);
    i_rd <= 1;
    i_addr <= a;
    @(posedge I_MCLK);
    i_rd <= 0;
    @(negedge I_MCLK);
    check("rdata", o_rdata, e);
    check("rvalid", o_rvalid, 8'h01);
  endtask
  task line(input logic s, h, input int n);
    @(posedge I_MCLK);
    short_cmd <= s;
    hot_cmd <= h;
    cyc(n);
  endtask
  initial begin
    void'($urandom(32'hEEE34CE6));
    repeat (4) @(posedge I_MCLK);
    I_RST <= 0;
    cyc(1);
    check("drv", o_drv_enable, 1);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    repeat (6) begin
      w = $urandom;
      wr(8'h05, w);
      cyc(1);
      check("level", o_current_limit_level, w[7:6]);
      check("limit", o_limit_active, !w[5]);
      rd(8'h05, w);
      wr(8'h06, w);
      cyc(1);
      check("ctl", {o_reg3v3_off, o_wake_detect_off, o_receive_output_off},
        {w[7], w[6], w[3]});
      rd(8'h06, ctl_exp(w));
      rd(8'h40 | w, 8'h00);
    end
    wr(8'h05, 8'h00);
    line(1, 0, 1000);
    check("fault", o_fault, 0);
    line(0, 0, 3);
    line(1, 0, 1400);
    check("fault", o_fault, 1);
    check("drv", o_drv_enable, 1);
    line(0, 1, 3);
    check("drv", o_drv_enable, 0);
    line(0, 0, 3);
    check("drv", o_drv_enable, 1);
    wr(8'h05, 8'h20);
    line(1, 0, 1400);
    check("fault", o_fault, 0);
    line(0, 0, 3);
    wr(8'h05, 8'h08);
    line(1, 0, 4900);
    check("fault", o_fault, 0);
    line(1, 0, 200);
    check("fault", o_fault, 1);
    line(0, 0, 3);
    wr(8'h05, 8'h01);
    line(1, 0, 1400);
    check("drv", o_drv_enable, 0);
    line(0, 0, 20);
    check("drv", o_drv_enable, 0);
    @(posedge I_MCLK);
    I_RST <= 1;
    cyc(2);
    check("drv", o_drv_enable, 0);
    @(posedge I_MCLK);
    I_RST <= 0;
    cyc(1);
    check("drv", o_drv_enable, 1);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    report_and_stop;
  end
endmodule

// ===== line_drv_assertions.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module line_drv_assertions
  import line_drv_pkg::*;
(
  input wire logic I_MCLK, I_RST, i_wr, i_rd, i_in_limit, i_overtemp,
  input wire logic [7:0] i_addr, i_wdata, o_rdata,
  input wire logic o_rvalid, o_drv_enable, o_limit_active, o_fault,
  input wire logic [1:0] o_current_limit_level,
  input wire logic o_reg3v3_off, o_wake_detect_off, o_receive_output_off
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  sequence wr_cfg; i_wr && i_addr == 8'h05; endsequence
  sequence wr_ctl; i_wr && i_addr == 8'h06; endsequence
  chk_rd_answer: assert property (i_rd |=> o_rvalid) else $error("no answer");
  chk_rd_idle: assert property (!i_rd |=> !o_rvalid) else $error("stray answer");
  chk_level_code: assert property (wr_cfg |-> ##2
    o_current_limit_level == $past(i_wdata[7:6], 2)) else $error("bad level");
  chk_limit_flag: assert property (wr_cfg |-> ##2
    o_limit_active == !$past(i_wdata[5], 2)) else $error("bad limit");
  chk_ctl_bits: assert property (wr_ctl |-> ##2
    {o_reg3v3_off, o_wake_detect_off, o_receive_output_off}
    == {$past(i_wdata[7], 2), $past(i_wdata[6], 2), $past(i_wdata[3], 2)})
    else $error("bad ctl");
  chk_blank_hold: assert property ($rose(i_in_limit) && !o_fault && !i_overtemp
    |=> (!o_fault || $past(i_overtemp)) [*8]) else $error("early fault");
  chk_hot_off: assert property (i_overtemp |-> ##[1:2] !o_drv_enable)
    else $error("hot on");
  chk_read_zero: assert property (i_rd && i_addr != 8'h05 && i_addr != 8'h06
    |=> o_rdata == 8'h00) else $error("bad empty read");
endmodule
bind line_driver_limit_retry_ctrl line_drv_assertions chk (.*);

// ===== line_drv_pkg.sv
// Purpose: constants and types for the line driver limit and retry control
// Assumes: 10 MHz clock, registers reached through a byte-wide register port
// Notes: times are named in their own unit, counts derived from the clock rate
// Contract
// - level field bits 7:6 picks current limit
// - bit 5 set disables current limit
// - field bits 4:3 picks overcurrent blanking time
// - field bits 2:1 picks retry off-time
// - auto retry: fault, hold off, re-enable
// - retry covers overcurrent and overtemperature faults
// - retry off: only thermal overload stops driver
// - control bit 7 set turns 3.3V regulator off
// - control bit 3 set floats receive output
// - control bit 6 set disables wake detection
package line_drv_pkg;
  localparam logic [7:0] ADDR_LIMIT_CFG = 8'h05;
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h06;
  localparam logic [7:0] RST_LIMIT_CFG = 8'h00;
  localparam logic [7:0] RST_GEN_CTRL = 8'h00;
  localparam logic [7:0] GEN_CTRL_MASK = 8'hFD;
  localparam int POS_REG3V3_OFF = 7;
  localparam int POS_WAKE_OFF = 6;
  localparam int POS_RX_OFF = 3;
  localparam int CLK_MHZ = 10;
  localparam int BLANK_US0 = 128;
  localparam int BLANK_US1 = 500;
  localparam int BLANK_MS2 = 1;
  localparam int BLANK_MS3 = 5;
  localparam int RETRY_MS0 = 50;
  localparam int RETRY_MS1 = 100;
  localparam int RETRY_MS2 = 200;
  localparam int RETRY_MS3 = 500;
  localparam int CNT_W = 23;
  localparam logic [CNT_W-1:0] BLANK_CYC0 = CNT_W'(BLANK_US0 * CLK_MHZ);
  localparam logic [CNT_W-1:0] BLANK_CYC1 = CNT_W'(BLANK_US1 * CLK_MHZ);
  localparam logic [CNT_W-1:0] BLANK_CYC2 = CNT_W'(BLANK_MS2 * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] BLANK_CYC3 = CNT_W'(BLANK_MS3 * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] RETRY_CYC0 = CNT_W'(RETRY_MS0 * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] RETRY_CYC1 = CNT_W'(RETRY_MS1 * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] RETRY_CYC2 = CNT_W'(RETRY_MS2 * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] RETRY_CYC3 = CNT_W'(RETRY_MS3 * 1000 * CLK_MHZ);
  typedef struct packed {
    logic [1:0] current_limit_level;
    logic limit_disable;
    logic [1:0] limit_blank_time;
    logic [1:0] retry_off_time;
    logic auto_retry_enable;
  } limit_cfg_t;
  typedef enum logic [1:0] {
    ST_ON = 2'b01,
    ST_OFF = 2'b10
  } drv_state_t;
endpackage

// ===== line_load.sv
// Purpose: line load that can short the driver
// Assumes: limiting only while driven
// Notes: overtemp follows command
`timescale 1ns/1ps
module line_load (
  input wire logic drv_on,
  input wire logic short_cmd,
  input wire logic hot_cmd,
  output logic in_limit,
  output logic overtemp
);
  assign in_limit = short_cmd && drv_on;
  assign overtemp = hot_cmd;
endmodule
